/* File: hdl/ddr3_init_core.sv */
// DRAM device model: reset, initialisation, power states, command decode and burst path
`timescale 1ns/10ps
// Notes on behaviour
// - Active opens a row chosen by address in one of eight banks.
// - Read/Write carry start column; A10 auto-precharge, A12 picks BC4 or BL8.
// - Eight beats gather into one wide core word, two beats per clock.
// - Clock enable falling with NOP or deselect from idle or active enters power-down.
// - Clock enable rising with NOP or deselect leaves power-down.
// - Data mask high blocks its write beat; low lets it store.
// - Device initialises internally after reset; controller waits 500us.
// - Termination stays off during reset and until clock enable registers high.
module ddr3_init_core #(
  parameter int INIT_CYCLES = ddr3_init_pkg::INIT_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // DRAM pins
  input wire logic ckPin,
  input wire logic resetPinN,
  input wire logic ckePin,
  input wire logic csPinN,
  input wire logic rasPinN,
  input wire logic casPinN,
  input wire logic wePinN,
  input wire logic odtPin,
  input wire logic dmPin,
  input wire logic [2:0] baPin,
  input wire logic [15:0] addrPin,
  input wire logic [7:0] dqIn,
  output logic [7:0] dqOut,
  output logic dqOeN,
  output logic termEn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata
);
  localparam logic [ddr3_init_pkg::INIT_CNT_W-1:0] INIT_LAST =
    ddr3_init_pkg::INIT_CNT_W'(INIT_CYCLES - 1);

  link_if lk ();
  ddr3_init_pkg::pin_type pins;

  assign pins = '{ck: ckPin, resetN: resetPinN, cke: ckePin, csN: csPinN, rasN: rasPinN,
                  casN: casPinN, weN: wePinN, odt: odtPin, dm: dmPin, ba: baPin,
                  addr: addrPin, dq: dqIn};

  link_sampler u_sampler (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pins(pins),
    .lk(lk)
  );

  ddr3_init_pkg::state_type state_q, state_d;
  ddr3_init_pkg::burst_type burst_q, burst_d;
  logic pdActive_q, pdActive_d;
  logic [ddr3_init_pkg::INIT_CNT_W-1:0] initCnt_q, initCnt_d;
  logic initDone_q, initDone_d;
  logic termArmed_q, termArmed_d;
  logic termEn_q, termEn_d;
  logic [7:0] bankOpen_q, bankOpen_d;
  logic [2:0] beat_q, beat_d;
  logic [2:0] lastBeat_q, lastBeat_d;
  logic [2:0] laneBase_q, laneBase_d;
  logic [5:0] bAddr_q, bAddr_d;
  logic ap_q, ap_d;
  logic [63:0] pf_q, pf_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] dqOut_q, dqOut_d;
  logic dqOeN_q, dqOeN_d;
  logic [1:0] blMode_q, blMode_d;
  logic [3:0] mrsSeen_q, mrsSeen_d;
  logic dllRst_q, dllRst_d;
  logic dllOn_q, dllOn_d;
  logic zqLong_q, zqLong_d;
  logic zqShort_q, zqShort_d;
  logic [15:0] wrCount_q, wrCount_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [2:0] rowSel_q, rowSel_d;
  logic [15:0] regRdata_q, regRdata_d;

  ddr3_init_pkg::cmd_type cmd;
  logic cmdOk, nopLike, ckeFall, ckeRise, ckeHigh, bc4;
  logic [2:0] lane;
  logic coreWe, rowWe;
  logic [7:0] coreLanes;
  logic [5:0] coreRaddr;
  logic [63:0] coreRdata;
  logic [15:0] rowRdata;

  tiny_ram #(.WIDTH(64), .DEPTH(64), .AW(6), .LANES(8)) u_core (
    .ref_clk(ref_clk),
    .we(coreWe),
    .laneEn(coreLanes),
    .waddr(bAddr_q),
    .wdata(pf_d),
    .raddr(coreRaddr),
    .rdata(coreRdata)
  );

  // Open row per bank, readable by software
  tiny_ram #(.WIDTH(16), .DEPTH(8), .AW(3), .LANES(1)) u_rows (
    .ref_clk(ref_clk),
    .we(rowWe),
    .laneEn(1'b1),
    .waddr(lk.ba),
    .wdata(lk.addr),
    .raddr(rowSel_q),
    .rdata(rowRdata)
  );

  always_comb begin
    cmd = ddr3_init_pkg::decode_cmd(lk.csN, lk.rasN, lk.casN, lk.weN);
    cmdOk = lk.ckRise;
    nopLike = (cmd == ddr3_init_pkg::CMD_NOP) || (cmd == ddr3_init_pkg::CMD_DES);
    ckeFall = lk.ckePrev && !lk.cke;
    ckeRise = !lk.ckePrev && lk.cke;
    ckeHigh = lk.ckePrev && lk.cke;
    case (blMode_q)
      ddr3_init_pkg::BL_FIXED4: bc4 = 1'b1;
      ddr3_init_pkg::BL_OTF: bc4 = !lk.addr[ddr3_init_pkg::A_BURST8];
      default: bc4 = 1'b0;
    endcase
    lane = 3'(laneBase_q + beat_q);
    coreRaddr = (burst_q != ddr3_init_pkg::BURST_NONE) ? bAddr_q
                : {lk.ba, lk.addr[ddr3_init_pkg::A_COLGRP_LO +: 3]};
  end

  always_comb begin
    state_d = state_q;
    burst_d = burst_q;
    pdActive_d = pdActive_q;
    initCnt_d = initCnt_q;
    initDone_d = initDone_q;
    termArmed_d = termArmed_q;
    bankOpen_d = bankOpen_q;
    beat_d = beat_q;
    lastBeat_d = lastBeat_q;
    laneBase_d = laneBase_q;
    bAddr_d = bAddr_q;
    ap_d = ap_q;
    pf_d = pf_q;
    mask_d = mask_q;
    dqOut_d = dqOut_q;
    dqOeN_d = dqOeN_q;
    blMode_d = blMode_q;
    mrsSeen_d = mrsSeen_q;
    dllRst_d = dllRst_q;
    dllOn_d = dllOn_q;
    zqLong_d = zqLong_q;
    zqShort_d = zqShort_q;
    wrCount_d = wrCount_q;
    coreWe = 1'b0;
    coreLanes = 8'h00;
    rowWe = 1'b0;

    // Burst engine: one beat per clock edge, the command edge itself carries none
    if ((lk.ckRise || lk.ckFall) && !(cmdOk && burst_q == ddr3_init_pkg::BURST_NONE)) begin
      dqOeN_d = 1'b1;
      if (burst_q == ddr3_init_pkg::BURST_WR) begin
        pf_d[lane*8 +: 8] = lk.dq;
        mask_d[lane] = lk.dm;
      end else if (burst_q == ddr3_init_pkg::BURST_RD) begin
        dqOut_d = coreRdata[lane*8 +: 8];
        dqOeN_d = 1'b0;
      end
      if (burst_q != ddr3_init_pkg::BURST_NONE) begin
        beat_d = 3'(beat_q + 3'h1);
        if (beat_q == lastBeat_q) begin
          burst_d = ddr3_init_pkg::BURST_NONE;
          if (burst_q == ddr3_init_pkg::BURST_WR) begin
            coreWe = 1'b1;
            for (int i = 0; i < 8; i++) begin
              coreLanes[i] = !mask_d[i];
            end
            wrCount_d = 16'(wrCount_q + 16'h0001);
          end
          if (ap_q) begin
            bankOpen_d[bAddr_q[5:3]] = 1'b0;
          end
        end
      end
    end

    case (state_q)
      ddr3_init_pkg::ST_RESET: begin
        if (lk.resetN) begin
          state_d = ddr3_init_pkg::ST_INIT;
        end
      end
      ddr3_init_pkg::ST_INIT: begin
        // Internal init runs on ref_clk, independent of the DRAM clock
        if (!initDone_q) begin
          initCnt_d = ddr3_init_pkg::INIT_CNT_W'(initCnt_q + 1'b1);
          initDone_d = (initCnt_q == INIT_LAST);
        end else if (cmdOk && lk.cke) begin
          state_d = ddr3_init_pkg::ST_IDLE;
          termArmed_d = 1'b1;
        end
      end
      ddr3_init_pkg::ST_IDLE, ddr3_init_pkg::ST_ACTIVE: begin
        if (cmdOk && ckeFall && nopLike) begin
          state_d = ddr3_init_pkg::ST_PDOWN;
          pdActive_d = (state_q == ddr3_init_pkg::ST_ACTIVE);
        end else if (cmdOk && ckeFall && cmd == ddr3_init_pkg::CMD_REF &&
                     state_q == ddr3_init_pkg::ST_IDLE) begin
          state_d = ddr3_init_pkg::ST_SREF;
        end else if (cmdOk && ckeHigh) begin
          case (cmd)
            ddr3_init_pkg::CMD_ACT: begin
              bankOpen_d[lk.ba] = 1'b1;
              rowWe = 1'b1;
            end
            ddr3_init_pkg::CMD_PRE: begin
              if (lk.addr[ddr3_init_pkg::A_AUTOPRE]) begin
                bankOpen_d = 8'h00;
              end else begin
                bankOpen_d[lk.ba] = 1'b0;
              end
            end
            ddr3_init_pkg::CMD_RD, ddr3_init_pkg::CMD_WR: begin
              if (bankOpen_q[lk.ba] && burst_q == ddr3_init_pkg::BURST_NONE) begin
                burst_d = (cmd == ddr3_init_pkg::CMD_WR) ? ddr3_init_pkg::BURST_WR
                          : ddr3_init_pkg::BURST_RD;
                beat_d = 3'h0;
                lastBeat_d = bc4 ? ddr3_init_pkg::LAST_BEAT_BC4
                             : ddr3_init_pkg::LAST_BEAT_BL8;
                laneBase_d = {bc4 && lk.addr[ddr3_init_pkg::A_COL_HALF], 2'b00};
                bAddr_d = {lk.ba, lk.addr[ddr3_init_pkg::A_COLGRP_LO +: 3]};
                ap_d = lk.addr[ddr3_init_pkg::A_AUTOPRE];
                mask_d = 8'hff; // Beats outside a chopped burst never store
              end
            end
            ddr3_init_pkg::CMD_MRS: begin
              if (state_q == ddr3_init_pkg::ST_IDLE) begin
                mrsSeen_d[lk.ba[1:0]] = 1'b1;
                if (lk.ba[1:0] == 2'h0) begin
                  blMode_d = lk.addr[1:0];
                  dllRst_d = lk.addr[ddr3_init_pkg::A_DLL_RST];
                end
                if (lk.ba[1:0] == 2'h1) begin
                  dllOn_d = !lk.addr[ddr3_init_pkg::A_DLL_OFF];
                end
              end
            end
            ddr3_init_pkg::CMD_ZQ: begin
              if (state_q == ddr3_init_pkg::ST_IDLE) begin
                zqLong_d = zqLong_q | lk.addr[ddr3_init_pkg::A_AUTOPRE];
                zqShort_d = zqShort_q | !lk.addr[ddr3_init_pkg::A_AUTOPRE];
              end
            end
            default: begin
            end
          endcase
        end
      end
      ddr3_init_pkg::ST_PDOWN: begin
        if (cmdOk && ckeRise && nopLike) begin
          state_d = pdActive_q ? ddr3_init_pkg::ST_ACTIVE : ddr3_init_pkg::ST_IDLE;
        end
      end
      ddr3_init_pkg::ST_SREF: begin
        if (cmdOk && ckeRise && nopLike) begin
          state_d = ddr3_init_pkg::ST_IDLE;
        end
      end
      default: state_d = ddr3_init_pkg::ST_RESET;
    endcase

    if (state_d == ddr3_init_pkg::ST_IDLE && bankOpen_d != 8'h00) begin
      state_d = ddr3_init_pkg::ST_ACTIVE;
    end else if (state_d == ddr3_init_pkg::ST_ACTIVE && bankOpen_d == 8'h00) begin
      state_d = ddr3_init_pkg::ST_IDLE;
    end

    // Reset pin low wins over everything; mode state becomes undefined, so cleared
    if (!lk.resetN) begin
      state_d = ddr3_init_pkg::ST_RESET;
      initCnt_d = '0;
      initDone_d = 1'b0;
      termArmed_d = 1'b0;
      bankOpen_d = 8'h00;
      burst_d = ddr3_init_pkg::BURST_NONE;
      dqOeN_d = 1'b1;
      mrsSeen_d = 4'h0;
      dllRst_d = 1'b0;
      dllOn_d = 1'b0;
      zqLong_d = 1'b0;
      zqShort_d = 1'b0;
      blMode_d = ddr3_init_pkg::BL_FIXED8;
      coreWe = 1'b0;
      rowWe = 1'b0;
    end
    termEn_d = termArmed_d && lk.odt && ctrl_q[ddr3_init_pkg::CTRL_TERM_BIT];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ddr3_init_pkg::ST_RESET;
      burst_q <= ddr3_init_pkg::BURST_NONE;
      pdActive_q <= 1'b0;
      initCnt_q <= '0;
      initDone_q <= 1'b0;
      termArmed_q <= 1'b0;
      termEn_q <= 1'b0;
      bankOpen_q <= 8'h00;
      beat_q <= 3'h0;
      lastBeat_q <= 3'h0;
      laneBase_q <= 3'h0;
      bAddr_q <= 6'h00;
      ap_q <= 1'b0;
      pf_q <= 64'h0;
      mask_q <= 8'h00;
      dqOut_q <= 8'h00;
      dqOeN_q <= 1'b1;
      blMode_q <= ddr3_init_pkg::BL_FIXED8;
      mrsSeen_q <= 4'h0;
      dllRst_q <= 1'b0;
      dllOn_q <= 1'b0;
      zqLong_q <= 1'b0;
      zqShort_q <= 1'b0;
      wrCount_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      burst_q <= burst_d;
      pdActive_q <= pdActive_d;
      initCnt_q <= initCnt_d;
      initDone_q <= initDone_d;
      termArmed_q <= termArmed_d;
      termEn_q <= termEn_d;
      bankOpen_q <= bankOpen_d;
      beat_q <= beat_d;
      lastBeat_q <= lastBeat_d;
      laneBase_q <= laneBase_d;
      bAddr_q <= bAddr_d;
      ap_q <= ap_d;
      pf_q <= pf_d;
      mask_q <= mask_d;
      dqOut_q <= dqOut_d;
      dqOeN_q <= dqOeN_d;
      blMode_q <= blMode_d;
      mrsSeen_q <= mrsSeen_d;
      dllRst_q <= dllRst_d;
      dllOn_q <= dllOn_d;
      zqLong_q <= zqLong_d;
      zqShort_q <= zqShort_d;
      wrCount_q <= wrCount_d;
    end
  end

  // Register port; read data stand only in the cycle after the strobe
  always_comb begin
    ctrl_d = ctrl_q;
    rowSel_d = rowSel_q;
    regRdata_d = 16'h0000;
    if (regWr && regAddr == ddr3_init_pkg::REG_CTRL) begin
      ctrl_d = {15'h0000, regWdata[ddr3_init_pkg::CTRL_TERM_BIT]};
    end
    if (regWr && regAddr == ddr3_init_pkg::REG_ROWSEL) begin
      rowSel_d = regWdata[2:0];
    end
    if (regRd) begin
      case (regAddr)
        ddr3_init_pkg::REG_CTRL: regRdata_d = ctrl_q;
        ddr3_init_pkg::REG_STATUS: regRdata_d = {6'h00, burst_q != ddr3_init_pkg::BURST_NONE,
                                                 termEn_q, termArmed_q, initDone_q, state_q};
        ddr3_init_pkg::REG_BANKS: regRdata_d = {8'h00, bankOpen_q};
        ddr3_init_pkg::REG_ROWSEL: regRdata_d = {13'h0000, rowSel_q};
        ddr3_init_pkg::REG_ROWDATA: regRdata_d = rowRdata;
        ddr3_init_pkg::REG_MODE: regRdata_d = {6'h00, blMode_q, zqShort_q, zqLong_q, dllOn_q,
                                               dllRst_q, mrsSeen_q};
        ddr3_init_pkg::REG_WRCOUNT: regRdata_d = wrCount_q;
        default: regRdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= ddr3_init_pkg::CTRL_RESET;
      rowSel_q <= 3'h0;
      regRdata_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      rowSel_q <= rowSel_d;
      regRdata_q <= regRdata_d;
    end
  end

  assign dqOut = dqOut_q;
  assign dqOeN = dqOeN_q;
  assign termEn = termEn_q;
  assign regRdata = regRdata_q;
endmodule // ddr3_init_core

/* File: hdl/ddr3_init_pkg.sv */
// Shared constants, types and command decoding for the DRAM power and init model
package ddr3_init_pkg;

  localparam int BANK_W = 3;
  localparam int ADDR_W = 16;
  localparam int DQ_W = 8;
  localparam int PREFETCH = 8;
  localparam int CORE_W = DQ_W * PREFETCH;
  localparam int CORE_AW = 6;
  localparam int CORE_DEPTH = 64;
  localparam int ROW_DEPTH = 8;

  // Internal state initialisation time after reset release
  localparam int INIT_TIME_US = 500;
  localparam int CLK_MHZ = 250;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int INIT_CNT_W = 20;

  // Register port
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_BANKS = 4'h2;
  localparam logic [3:0] REG_ROWSEL = 4'h3;
  localparam logic [3:0] REG_ROWDATA = 4'h4;
  localparam logic [3:0] REG_MODE = 4'h5;
  localparam logic [3:0] REG_WRCOUNT = 4'h6;
  localparam logic [15:0] CTRL_RESET = 16'h0001;
  localparam int CTRL_TERM_BIT = 0;

  // Address bit positions on commands
  localparam int A_DLL_OFF = 0;
  localparam int A_DLL_RST = 8;
  localparam int A_AUTOPRE = 10;
  localparam int A_BURST8 = 12;
  localparam int A_COL_HALF = 2;
  localparam int A_COLGRP_LO = 3;

  // Burst length field of mode register 0
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [2:0] LAST_BEAT_BC4 = 3'h3;
  localparam logic [2:0] LAST_BEAT_BL8 = 3'h7;

  typedef struct packed {
    logic ck;
    logic resetN;
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic odt;
    logic dm;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq;
  } pin_type;

  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_INIT = 6'h02,
    ST_IDLE = 6'h04,
    ST_ACTIVE = 6'h08,
    ST_PDOWN = 6'h10,
    ST_SREF = 6'h20
  } state_type;

  typedef enum logic [3:0] {
    CMD_DES, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_ZQ
  } cmd_type;

  typedef enum logic [1:0] {BURST_NONE, BURST_WR, BURST_RD} burst_type;

  function automatic cmd_type decode_cmd(input logic csN, input logic rasN,
                                         input logic casN, input logic weN);
    cmd_type c;
    c = CMD_DES;
    if (!csN) begin
      case ({rasN, casN, weN})
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACT;
        3'h5: c = CMD_RD;
        3'h4: c = CMD_WR;
        3'h2: c = CMD_PRE;
        3'h1: c = CMD_REF;
        3'h0: c = CMD_MRS;
        3'h6: c = CMD_ZQ;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

endpackage

/* File: hdl/link_if.sv */
// Sampled DRAM pin bundle passed from the pin sampler to the core logic
`timescale 1ns/10ps
interface link_if;
  logic ckRise;
  logic ckFall;
  logic resetN;
  logic cke;
  logic ckePrev;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic odt;
  logic dm;
  logic [ddr3_init_pkg::BANK_W-1:0] ba;
  logic [ddr3_init_pkg::ADDR_W-1:0] addr;
  logic [ddr3_init_pkg::DQ_W-1:0] dq;

  modport sampler (output ckRise, ckFall, resetN, cke, ckePrev, csN, rasN, casN, weN,
                   odt, dm, ba, addr, dq);
  modport core (input ckRise, ckFall, resetN, cke, ckePrev, csN, rasN, casN, weN,
                odt, dm, ba, addr, dq);
endinterface

/* File: hdl/link_sampler.sv */
// Two-stage synchroniser and clock edge finder for the DRAM pins
`timescale 1ns/10ps
module link_sampler (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Pins
  input wire ddr3_init_pkg::pin_type pins,
  // Sampled bundle
  link_if.sampler lk
);
  ddr3_init_pkg::pin_type sync1_q;
  ddr3_init_pkg::pin_type sync2_q;
  logic ckLast_q;
  logic rise;
  logic fall;

  always_comb begin
    rise = sync2_q.ck & ~ckLast_q;
    fall = ~sync2_q.ck & ckLast_q;
  end

  // Command pins are latched only at the rising edge; data at both edges
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      ckLast_q <= 1'b0;
      lk.ckRise <= 1'b0;
      lk.ckFall <= 1'b0;
      lk.resetN <= 1'b0;
      lk.cke <= 1'b0;
      lk.ckePrev <= 1'b0;
      lk.csN <= 1'b1;
      lk.rasN <= 1'b1;
      lk.casN <= 1'b1;
      lk.weN <= 1'b1;
      lk.odt <= 1'b0;
      lk.dm <= 1'b0;
      lk.ba <= '0;
      lk.addr <= '0;
      lk.dq <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      ckLast_q <= sync2_q.ck;
      lk.ckRise <= rise;
      lk.ckFall <= fall;
      lk.resetN <= sync2_q.resetN;
      lk.odt <= sync2_q.odt;
      if (rise) begin
        lk.cke <= sync2_q.cke;
        lk.ckePrev <= lk.cke;
        lk.csN <= sync2_q.csN;
        lk.rasN <= sync2_q.rasN;
        lk.casN <= sync2_q.casN;
        lk.weN <= sync2_q.weN;
        lk.ba <= sync2_q.ba;
        lk.addr <= sync2_q.addr;
      end
      if (rise || fall) begin
        lk.dq <= sync2_q.dq;
        lk.dm <= sync2_q.dm;
      end
    end
  end
endmodule // link_sampler

/* File: hdl/tiny_ram.sv */
// Small simple dual port memory with lane write enables and registered read data
`timescale 1ns/10ps
module tiny_ram #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int LANES = 8
) (
  // Clock
  input wire logic ref_clk,
  // Write side
  input wire logic we,
  input wire logic [LANES-1:0] laneEn,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  localparam int LW = WIDTH / LANES;

  // No reset on the array: contents are undefined until written, as in the core
  // Each lane keeps an array of its own, so no two processes write one variable
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [LW-1:0] mem [DEPTH];
    logic [LW-1:0] laneRd_q;
    always_ff @(posedge ref_clk) begin
      if (we && laneEn[i]) begin
        mem[waddr] <= wdata[i*LW +: LW];
      end
      laneRd_q <= mem[raddr];
    end
    assign rdata[i*LW +: LW] = laneRd_q;
  end
endmodule // tiny_ram

/* File: tb/ddr3_ctrl_model.sv */
// Controller model driving the DRAM pins
`timescale 1ns/10ps
module ddr3_ctrl_model (
  // DRAM pins
  output logic ckPin,
  output logic resetPinN,
  output logic ckePin,
  output logic csPinN,
  output logic rasPinN,
  output logic casPinN,
  output logic wePinN,
  output logic odtPin,
  output logic dmPin,
  output logic [2:0] baPin,
  output logic [15:0] addrPin,
  output logic [7:0] dqIn
);
  // Edges on odd ns stay clear of ref_clk edges
  initial begin
    {ckPin, resetPinN, ckePin, odtPin, dmPin} = 5'h02;
    {csPinN, rasPinN, casPinN, wePinN} = 4'h7;
    {baPin, addrPin, dqIn} = 27'h0;
    #1;
    forever #24 ckPin = ~ckPin;
  end
  // Command launched at the falling edge, taken at the next rise
  task automatic cmd(input logic [3:0] c, input logic e, input logic [2:0] b,
                     input logic [15:0] a, input int n, input logic [7:0] d,
                     input logic [7:0] m);
    @(negedge ckPin);
    {csPinN, rasPinN, casPinN, wePinN} = c;
    ckePin = e;
    baPin = b;
    addrPin = a;
    @(posedge ckPin);
    #12;
    {csPinN, rasPinN, casPinN, wePinN} = 4'h7;
    for (int k = 0; k < n; k++) begin
      dqIn = d + 8'(k);
      dmPin = m[k];
      @(ckPin);
      #12;
    end
    // Released lines flip so a stale value never looks valid
    dqIn = ~dqIn;
    dmPin = ~dmPin;
  endtask
  task automatic pins(input logic r, input logic o);
    @(negedge ckPin);
    if (!r) begin
      ckePin = 1'b0;
    end
    resetPinN = r;
    odtPin = o;
  endtask
endmodule // ddr3_ctrl_model

/* File: tb/ddr3_init_properties.sv */
// Port checks for the DRAM init core
`timescale 1ns/10ps
module ddr3_init_properties #(
  parameter int INIT_CYCLES = 20
) (
  // Clock, resets and pins
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic resetPinN,
  input wire logic ckePin,
  input wire logic odtPin,
  // Data and termination
  input wire logic [7:0] dqOut,
  input wire logic dqOeN,
  input wire logic termEn,
  // Register port
  input wire logic regRd,
  input wire logic [15:0] regRdata
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  AST_TERM_RST: assert property ((!resetPinN) [*6] |-> !termEn)
    else $error("termination on in reset");
  AST_DQ_RST: assert property ((!resetPinN) [*6] |-> dqOeN)
    else $error("data driven in reset");
  AST_TERM_ODT: assert property ((!odtPin) [*6] |-> !termEn)
    else $error("termination without control input");
  AST_TERM_ARM: assert property ($rose(termEn) |-> $past(resetPinN, 8))
    else $error("termination armed too early");
  AST_BURST_LEN: assert property ($fell(dqOeN) |-> !dqOeN [*8] ##[12:44] $rose(dqOeN))
    else $error("read burst length");
  AST_BEAT_HOLD: assert property (!dqOeN && $changed(dqOut) |=> $stable(dqOut) [*3])
    else $error("read beat too short");
  AST_PD_QUIET: assert property ((!ckePin) [*8] |-> !$fell(dqOeN))
    else $error("read started with clock enable low");
  AST_RD_SLOT: assert property (!$past(regRd) |-> regRdata == 16'h0)
    else $error("read data outside read slot");
  cover property ($fell(dqOeN));
  cover property ($rose(termEn));
  cover property (ckePin ##1 !ckePin);
endmodule // ddr3_init_properties

bind ddr3_init_core ddr3_init_properties #(.INIT_CYCLES(INIT_CYCLES)) props (.*);

/* File: tb/tb_ddr3_init_core.sv */
// Self-checking bench for the DRAM init core
`timescale 1ns/10ps
module tb_ddr3_init_core;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0;
  logic ckPin, resetPinN, ckePin, csPinN, rasPinN, casPinN, wePinN, odtPin, dmPin;
  logic dqOeN, termEn;
  logic [2:0] baPin;
  logic [15:0] addrPin, regRdata;
  logic [7:0] dqIn, dqOut;
  logic [2:0] mb[4] = '{3'h2, 3'h3, 3'h1, 3'h0};
  logic [15:0] ma[4] = '{16'h0, 16'h0, 16'h0, 16'h0101};
  logic [3:0] pc[9] = '{4'h3, 4'h7, 4'h7, 4'h2, 4'h7, 4'h7, 4'h1, 4'h7, 4'h6};
  logic pe[9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [15:0] ps[9] = '{16'h8, 16'h10, 16'h8, 16'h4, 16'h10, 16'h4, 16'h20, 16'h4, 16'h4};
  int numErrors = 0;
  int numChecks = 0;
  int cycles = 0;
  ddr3_ctrl_model ctl (.*);
  ddr3_init_core #(.INIT_CYCLES(20)) DUT (.*);
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      numErrors++;
      endSim();
    end
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
    numChecks++;
    if (v !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, v);
      numErrors++;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk("register", e, regRdata & m);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic op(input logic [3:0] c, input logic e, input logic [15:0] a,
                    input logic [15:0] s);
    ctl.cmd(c, e, 3'h0, a, 0, 8'h0, 8'h0);
    repeat (6) @(posedge ref_clk);
    rd(4'h1, 16'h003f, s);
  endtask
  task automatic rdb(input int base, input int n);
    int w;
    w = 0;
    // Sample between clock edges so no compare races the edge that moves the data
    while (dqOeN !== 1'b0 && w < 60) begin
      @(posedge ref_clk);
      #1;
      w++;
    end
    chk("dqOeN start", 16'h0, {15'h0, dqOeN});
    #12;
    for (int k = 0; k < n; k++) begin
      chk("beat", (base + k == 2) ? 16'h12 : 16'(8'h20 + base + k), {8'h0, dqOut});
      #24; // One beat per half link clock period
    end
    chk("dqOeN", 16'h1, {15'h0, dqOeN});
  endtask
  task automatic tInit();
    rd(4'h0, 16'hffff, 16'h0001);
    rd(4'hf, 16'hffff, 16'h0000);
    rd(4'h1, 16'h003f, 16'h0001);
    chk("termEn", 16'h0, {15'h0, termEn});
    ctl.pins(1'b1, 1'b1);
    repeat (40) @(posedge ref_clk);
    rd(4'h1, 16'h003f, 16'h0002);
    chk("termEn", 16'h0, {15'h0, termEn});
    op(4'h7, 1'b1, 16'h0, 16'h0004);
    chk("termEn", 16'h1, {15'h0, termEn});
    repeat (5) ctl.cmd(4'h7, 1'b1, 3'h0, 16'h0, 0, 8'h0, 8'h0);
    foreach (mb[i]) ctl.cmd(4'h0, 1'b1, mb[i], ma[i], 0, 8'h0, 8'h0);
    ctl.cmd(4'h6, 1'b1, 3'h0, 16'h0400, 0, 8'h0, 8'h0);
    rd(4'h5, 16'h03ff, 16'h017f);
    $display("test init done");
  endtask
  task automatic tRw();
    ctl.cmd(4'h3, 1'b1, 3'h3, 16'h1234, 0, 8'h0, 8'h0);
    rd(4'h2, 16'h00ff, 16'h0008);
    wr(4'h3, 16'h0003);
    rd(4'h4, 16'hffff, 16'h1234);
    ctl.cmd(4'h4, 1'b1, 3'h3, 16'h1000, 8, 8'h10, 8'h00);
    ctl.cmd(4'h4, 1'b1, 3'h3, 16'h1000, 8, 8'h20, 8'h04);
    repeat (8) @(posedge ref_clk);
    rd(4'h6, 16'hffff, 16'h0002);
    fork
      ctl.cmd(4'h5, 1'b1, 3'h3, 16'h1000, 0, 8'h0, 8'h0);
      rdb(0, 8);
    join
    fork
      ctl.cmd(4'h5, 1'b1, 3'h3, 16'h0404, 0, 8'h0, 8'h0);
      rdb(4, 4);
    join
    repeat (20) @(posedge ref_clk);
    rd(4'h2, 16'h00ff, 16'h0000);
    $display("test read write done");
  endtask
  task automatic tPower();
    foreach (pc[i]) op(pc[i], pe[i], (i == 3) ? 16'h0400 : 16'h0, ps[i]);
    rd(4'h5, 16'h0080, 16'h0080);
    $display("test power done");
  endtask
  task automatic tWarm();
    wr(4'h0, 16'h0000);
    repeat (3) @(posedge ref_clk);
    chk("termEn", 16'h0, {15'h0, termEn});
    wr(4'h0, 16'h0001);
    ctl.pins(1'b0, 1'b1);
    repeat (30) @(posedge ref_clk);
    rd(4'h1, 16'h003f, 16'h0001);
    rd(4'h5, 16'h00ff, 16'h0000);
    chk("termEn", 16'h0, {15'h0, termEn});
    ctl.pins(1'b1, 1'b0);
    repeat (40) @(posedge ref_clk);
    op(4'h7, 1'b1, 16'h0, 16'h0004);
    chk("termEn", 16'h0, {15'h0, termEn});
    $display("test warm reset done");
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    tInit();
    tRw();
    tPower();
    tWarm();
    endSim();
  end
endmodule // tb_ddr3_init_core
